// >>> rtl/cwp_pkg.sv
package cwp_pkg;

	// ------------------------------------------------------------
	// address spaces and widths
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 16;
	localparam int          WORD_W     = 14;
	localparam int          EE_W       = 8;
	localparam logic        SPACE_PROG = 1'h0;
	localparam logic        SPACE_EE   = 1'h1;

	// user id words sit above program memory
	localparam logic [15:0] ID_BASE    = 16'h8000;
	localparam logic [15:0] ID_LAST    = 16'h8003;
	localparam int          ID_COUNT   = 4;
	localparam logic [13:0] ID_RST     = 14'h0000;

	// ------------------------------------------------------------
	// self-write guard: end of the shielded region, per size code
	// ------------------------------------------------------------
	localparam logic [1:0]  WRSZ_ALL   = 2'h0;
	localparam logic [1:0]  WRSZ_HALF  = 2'h1;
	localparam logic [1:0]  WRSZ_BOOT  = 2'h2;
	localparam logic [1:0]  WRSZ_OFF   = 2'h3;
	localparam logic [15:0] LIM_ALL    = 16'h4000;
	localparam logic [15:0] LIM_HALF   = 16'h2000;
	localparam logic [15:0] LIM_BOOT   = 16'h0200;
	localparam logic [15:0] LIM_OFF    = 16'h0000;

	// values held until the settings are captured: fully guarded
	localparam logic        GUARD_RST  = 1'h0;
	localparam logic [1:0]  WRSZ_RST   = 2'h0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        space;
		logic [15:0] addr;
		logic [13:0] wdata;
	} cwp_req_t;

	typedef struct packed {
		logic        valid;
		logic        refused;
		logic [13:0] rdata;
	} cwp_rsp_t;

	typedef struct packed {
		logic        loaded;
		logic        programReadGuardN;
		logic        eepromGuardN;
		logic [1:0]  selfWriteGuardSize;
	} cwp_cfg_t;

	// where the answer of an accepted request comes from
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_MEM  = 2'b01,
		SRC_DENY = 2'b10,
		SRC_ID   = 2'b11
	} cwp_src_t;

	typedef struct packed {
		cwp_src_t    src;
		logic        write;
		logic        space;
		logic [1:0]  idIdx;
	} cwp_pend_t;

	typedef struct packed {
		logic [3:0][13:0] word;
	} cwp_id_state_t;

endpackage

// >>> rtl/cwp_user_id.sv
`timescale 1ns/1ps
`default_nettype none

module cwp_user_id (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        wrEn,
	input  wire logic [1:0]  wrIdx,
	input  wire logic [13:0] wrData,
	input  wire logic [1:0]  rdIdxA,
	input  wire logic [1:0]  rdIdxB,
	output var  logic [13:0] rdDataA,
	output var  logic [13:0] rdDataB
);

	cwp_pkg::cwp_id_state_t s_r;
	cwp_pkg::cwp_id_state_t s_nxt;

	// one write port; the caller settles who gets it
	always_comb begin
		s_nxt = s_r;
		if (wrEn) begin
			s_nxt.word[wrIdx] = wrData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= {cwp_pkg::ID_COUNT{cwp_pkg::ID_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// read ports look at stored words, so a write shows one edge later
	assign rdDataA = s_r.word[rdIdxA];
	assign rdDataB = s_r.word[rdIdxB];

endmodule

`default_nettype wire

// >>> rtl/cwp_guard.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: program and eeprom guards act independently
// R2: guarded program: external writes refused, reads zero
// R3: cpu program reads never blocked by guard
// R4: guarded eeprom: external reads and writes blocked
// R5: cpu eeprom reads and writes always allowed; the code takes none before the settings are captured
// R6: cpu program writes follow self-write guard only
// R7: size field sets shielded region; others writable
// R8: four user id words, cpu read/write
// R9: settings captured after reset, then held
module cwp_guard (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              cfgProgramReadGuardN,
	input  wire logic              cfgEepromGuardN,
	input  wire logic [1:0]        cfgSelfWriteGuardSize,
	input  wire cwp_pkg::cwp_req_t extReq,
	input  wire cwp_pkg::cwp_req_t cpuReq,
	input  wire logic [13:0]       extMemRdata,
	input  wire logic [13:0]       cpuMemRdata,
	output var  cwp_pkg::cwp_req_t extMem,
	output var  cwp_pkg::cwp_req_t cpuMem,
	output var  cwp_pkg::cwp_rsp_t extRsp,
	output var  cwp_pkg::cwp_rsp_t cpuRsp
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cwp_pkg::cwp_cfg_t  cfg;
		cwp_pkg::cwp_req_t  extMem;
		cwp_pkg::cwp_req_t  cpuMem;
		cwp_pkg::cwp_pend_t extPend;
		cwp_pkg::cwp_pend_t cpuPend;
		cwp_pkg::cwp_rsp_t  extRsp;
		cwp_pkg::cwp_rsp_t  cpuRsp;
	} cwp_state_t;

	cwp_state_t       s_r;
	cwp_state_t       s_nxt;
	cwp_pkg::cwp_src_t srcExt;
	cwp_pkg::cwp_src_t srcCpu;
	logic             idWe;
	logic [1:0]       idWrIdx;
	logic [13:0]      idWrData;
	logic [13:0]      idDataExt;
	logic [13:0]      idDataCpu;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic isId(input cwp_pkg::cwp_req_t r);
		return r.space == cwp_pkg::SPACE_PROG &&
			r.addr >= cwp_pkg::ID_BASE && r.addr <= cwp_pkg::ID_LAST;
	endfunction

	// end of the shielded region, counted from address zero
	// R7: region size decode
	function automatic logic [15:0] wrLimit(input logic [1:0] sz);
		logic [15:0] lim;
		lim = cwp_pkg::LIM_OFF;
		case (sz)
			cwp_pkg::WRSZ_ALL:  lim = cwp_pkg::LIM_ALL;
			cwp_pkg::WRSZ_HALF: lim = cwp_pkg::LIM_HALF;
			cwp_pkg::WRSZ_BOOT: lim = cwp_pkg::LIM_BOOT;
			default:            lim = cwp_pkg::LIM_OFF;
		endcase
		return lim;
	endfunction

	// decide where a request goes; nothing is taken before capture
	function automatic cwp_pkg::cwp_src_t classify(
		input cwp_pkg::cwp_req_t r,
		input logic              fromCpu,
		input cwp_pkg::cwp_cfg_t c
	);
		cwp_pkg::cwp_src_t v;
		v = cwp_pkg::SRC_MEM;
		if (!r.valid || !c.loaded) begin
			v = cwp_pkg::SRC_NONE;
		end else if (isId(r)) begin
			v = cwp_pkg::SRC_ID;
		end else if (fromCpu) begin
			// R5: cpu eeprom never guarded
			// R6: self-write check
			if (r.space == cwp_pkg::SPACE_PROG && r.write &&
				r.addr < wrLimit(c.selfWriteGuardSize)) begin
				v = cwp_pkg::SRC_DENY;
			end
		end else if (r.space == cwp_pkg::SPACE_PROG) begin
			// R2: external program guard
			if (!c.programReadGuardN) begin
				v = cwp_pkg::SRC_DENY;
			end
		end else if (!c.eepromGuardN) begin
			// R1 R4: eeprom guard alone decides
			v = cwp_pkg::SRC_DENY;
		end
		return v;
	endfunction

	// answer data; eeprom words are narrower than program words
	function automatic cwp_pkg::cwp_rsp_t answer(
		input cwp_pkg::cwp_pend_t p,
		input logic [13:0]        memData,
		input logic [13:0]        idData
	);
		cwp_pkg::cwp_rsp_t a;
		a = '0;
		a.valid   = p.src != cwp_pkg::SRC_NONE;
		a.refused = p.src == cwp_pkg::SRC_DENY;
		if (!p.write && p.src == cwp_pkg::SRC_MEM) begin
			a.rdata = (p.space == cwp_pkg::SPACE_EE) ?
				{6'h00, memData[7:0]} : memData;
		end else if (!p.write && p.src == cwp_pkg::SRC_ID) begin
			a.rdata = idData;
		end
		return a;
	endfunction

	// ------------------------------------------------------------
	// user id store
	// ------------------------------------------------------------
	cwp_user_id u_id (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.wrEn    (idWe),
		.wrIdx   (idWrIdx),
		.wrData  (idWrData),
		.rdIdxA  (s_r.extPend.idIdx),
		.rdIdxB  (s_r.cpuPend.idIdx),
		.rdDataA (idDataExt),
		.rdDataB (idDataCpu)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt  = s_r;
		srcCpu = classify(cpuReq, 1'h1, s_r.cfg);
		srcExt = classify(extReq, 1'h0, s_r.cfg);
		// R8: one id write per cycle, cpu first
		if (srcExt == cwp_pkg::SRC_ID && extReq.write &&
			srcCpu == cwp_pkg::SRC_ID && cpuReq.write) begin
			srcExt = cwp_pkg::SRC_DENY;
		end
		idWe     = 1'h0;
		idWrIdx  = extReq.addr[1:0];
		idWrData = extReq.wdata;
		if (srcCpu == cwp_pkg::SRC_ID && cpuReq.write) begin
			idWe     = 1'h1;
			idWrIdx  = cpuReq.addr[1:0];
			idWrData = cpuReq.wdata;
		end else if (srcExt == cwp_pkg::SRC_ID && extReq.write) begin
			idWe = 1'h1;
		end
		// R9: capture settings once, first edge after reset
		if (!s_r.cfg.loaded) begin
			s_nxt.cfg.loaded             = 1'h1;
			s_nxt.cfg.programReadGuardN  = cfgProgramReadGuardN;
			s_nxt.cfg.eepromGuardN       = cfgEepromGuardN;
			s_nxt.cfg.selfWriteGuardSize = cfgSelfWriteGuardSize;
		end
		// R3: after capture, cpu path reaches memory unless self-write blocks it or the address is a user id word
		s_nxt.cpuMem = (srcCpu == cwp_pkg::SRC_MEM) ? cpuReq : '0;
		s_nxt.extMem = (srcExt == cwp_pkg::SRC_MEM) ? extReq : '0;
		s_nxt.cpuPend = {srcCpu, cpuReq.write, cpuReq.space,
			cpuReq.addr[1:0]};
		s_nxt.extPend = {srcExt, extReq.write, extReq.space,
			extReq.addr[1:0]};
		// R2: refused answers carry zero data
		s_nxt.extRsp = answer(s_r.extPend, extMemRdata, idDataExt);
		s_nxt.cpuRsp = answer(s_r.cpuPend, cpuMemRdata, idDataCpu);
	end

	// register the whole state; guards start fully closed
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.cfg.programReadGuardN  <= cwp_pkg::GUARD_RST;
			s_r.cfg.eepromGuardN       <= cwp_pkg::GUARD_RST;
			s_r.cfg.selfWriteGuardSize <= cwp_pkg::WRSZ_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign extMem = s_r.extMem;
	assign cpuMem = s_r.cpuMem;
	assign extRsp = s_r.extRsp;
	assign cpuRsp = s_r.cpuRsp;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic extProg;
	logic extEe;
	logic cpuProg;
	logic cpuEe;
	logic cpuBelow;
	assign extProg  = extReq.valid && !isId(extReq) && s_r.cfg.loaded &&
		extReq.space == cwp_pkg::SPACE_PROG;
	assign extEe    = extReq.valid && s_r.cfg.loaded &&
		extReq.space == cwp_pkg::SPACE_EE;
	assign cpuProg  = cpuReq.valid && !isId(cpuReq) && s_r.cfg.loaded &&
		cpuReq.space == cwp_pkg::SPACE_PROG;
	assign cpuEe    = cpuReq.valid && s_r.cfg.loaded &&
		cpuReq.space == cwp_pkg::SPACE_EE;
	assign cpuBelow = cpuReq.addr < wrLimit(s_r.cfg.selfWriteGuardSize);

	sequence denied_s(logic m, cwp_pkg::cwp_rsp_t r);
		!m ##1 r.valid && r.refused && r.rdata == 14'h0000;
	endsequence

	sequence served_s(logic m, cwp_pkg::cwp_rsp_t r);
		m ##1 r.valid && !r.refused;
	endsequence

	// R2: guarded program access
	ext_prog_guard_a: assert property ( // R2
		extProg && !s_r.cfg.programReadGuardN |->
			##1 denied_s(extMem.valid, extRsp))
		else $error("guarded program access reached memory");

	// R4: guarded eeprom access
	ext_ee_guard_a: assert property ( // R4
		extEe && !s_r.cfg.eepromGuardN |->
			##1 denied_s(extMem.valid, extRsp))
		else $error("guarded eeprom access reached memory");

	// R1: eeprom guard ignores program guard
	guard_indep_a: assert property ( // R1
		extEe && s_r.cfg.eepromGuardN && !s_r.cfg.programReadGuardN |->
			##1 served_s(extMem.valid && extMem.space, extRsp))
		else $error("eeprom access blocked by program guard");

	// R3: cpu program read
	cpu_prog_read_a: assert property ( // R3
		cpuProg && !cpuReq.write |->
			##1 served_s(cpuMem.valid, cpuRsp))
		else $error("cpu program read was blocked");

	// R5: cpu eeprom access
	cpu_ee_access_a: assert property ( // R5
		cpuEe |-> ##1 served_s(cpuMem.valid &&
			cpuMem.write == $past(cpuReq.write), cpuRsp))
		else $error("cpu eeprom access was blocked");

	// R6: cpu write outside region passes even when guarded
	self_write_ok_a: assert property ( // R6
		cpuProg && cpuReq.write && !cpuBelow |->
			##1 served_s(cpuMem.valid && cpuMem.write, cpuRsp))
		else $error("cpu write outside region refused");

	// R7: cpu write inside shielded region
	self_write_deny_a: assert property ( // R7
		cpuProg && cpuReq.write && cpuBelow |->
			##1 denied_s(cpuMem.valid, cpuRsp))
		else $error("cpu write inside shielded region passed");

	// R8: id word written then read back
	sequence id_wr_rd_s;
		cpuReq.valid && cpuReq.write && isId(cpuReq) && s_r.cfg.loaded
		##1 cpuReq.valid && !cpuReq.write && isId(cpuReq) &&
			cpuReq.addr == $past(cpuReq.addr) &&
			!(extReq.valid && extReq.write && isId(extReq));
	endsequence
	id_readback_a: assert property ( // R8
		id_wr_rd_s |-> ##2 cpuRsp.valid &&
			cpuRsp.rdata == $past(cpuReq.wdata, 3))
		else $error("user id word did not read back");

	// R9: settings held once captured
	cfg_hold_a: assert property ( // R9
		s_r.cfg.loaded |=> s_r.cfg.loaded && $stable(s_r.cfg))
		else $error("protection settings changed after capture");

endmodule

`default_nettype wire

// >>> tb/cwp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

// programmer tool: one request at a time, held for its taking edge only
module cwp_prog_model (
	input  wire logic              mclk,
	output var  cwp_pkg::cwp_req_t extReq,
	input  wire cwp_pkg::cwp_rsp_t extRsp,
	input  wire cwp_pkg::cwp_req_t extMem
);
	initial extReq = '0;

	// ----------------------------------------
	// one access, entered at a rising edge
	// ----------------------------------------
	task automatic access(input logic wr, input logic sp,
		input logic [15:0] a, input logic [13:0] d,
		output cwp_pkg::cwp_req_t m, output cwp_pkg::cwp_rsp_t r);
		cwp_pkg::cwp_req_t q;
		q = '{valid:1'h1, write:wr, space:sp, addr:a, wdata:d};
		extReq <= q;
		@(posedge mclk);
		// released fields flip so stale values never pass as held ones
		extReq <= {1'h0, ~q[$bits(q)-2:0]};
		#1 m = extMem;
		@(posedge mclk);
		#1 r = extRsp;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_code_and_write_protection.sv
`timescale 1ns/1ps
`default_nettype none

module tb_code_and_write_protection;
	logic              mclk;
	logic              rst_n;
	logic              cfgP;
	logic              cfgE;
	logic [1:0]        cfgS;
	cwp_pkg::cwp_req_t extReq;
	cwp_pkg::cwp_req_t cpuReq;
	cwp_pkg::cwp_req_t extMem;
	cwp_pkg::cwp_req_t cpuMem;
	cwp_pkg::cwp_rsp_t extRsp;
	cwp_pkg::cwp_rsp_t cpuRsp;
	logic [13:0]       extMemRdata;
	logic [13:0]       cpuMemRdata;
	int                miscompares;
	int                checked;
	logic [15:0]       lims [4];

	function automatic logic [13:0] pat(input logic [15:0] a);
		return a[13:0] ^ 14'h2C35;
	endfunction

	// memories answer only while asked; otherwise the bus shows junk
	assign extMemRdata = extMem.valid ? pat(extMem.addr) :
		~pat(extMem.addr);
	assign cpuMemRdata = cpuMem.valid ? pat(cpuMem.addr) :
		~pat(cpuMem.addr);

	cwp_guard dut (.mclk(mclk), .rst_n(rst_n), .cfgProgramReadGuardN(cfgP),
		.cfgEepromGuardN(cfgE), .cfgSelfWriteGuardSize(cfgS),
		.extReq(extReq), .cpuReq(cpuReq), .extMemRdata(extMemRdata),
		.cpuMemRdata(cpuMemRdata), .extMem(extMem), .cpuMem(cpuMem),
		.extRsp(extRsp), .cpuRsp(cpuRsp));

	cwp_prog_model prog (.mclk(mclk), .extReq(extReq), .extRsp(extRsp),
		.extMem(extMem));

	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// cpu side, same timing as the programmer model
	task automatic cpu_access(input logic wr, input logic sp,
		input logic [15:0] a, input logic [13:0] d,
		output cwp_pkg::cwp_req_t m, output cwp_pkg::cwp_rsp_t r);
		cwp_pkg::cwp_req_t q;
		q = '{valid:1'h1, write:wr, space:sp, addr:a, wdata:d};
		cpuReq <= q;
		@(posedge mclk);
		cpuReq <= {1'h0, ~q[$bits(q)-2:0]};
		#1 m = cpuMem;
		@(posedge mclk);
		#1 r = cpuRsp;
	endtask

	// one transfer with its full judgement
	task automatic xfer(input logic cpu, input logic wr, input logic sp,
		input logic [15:0] a, input logic [13:0] d, input logic fwd,
		input logic rf, input logic [13:0] e);
		cwp_pkg::cwp_req_t m;
		cwp_pkg::cwp_rsp_t r;
		@(posedge mclk);
		if (cpu)
			cpu_access(wr, sp, a, d, m, r);
		else
			prog.access(wr, sp, a, d, m, r);
		chk("mem valid", 16'(fwd), 16'(m.valid));
		if (fwd)
			chk("mem addr", a, m.addr);
		if (fwd)
			chk("mem kind", 16'({wr, sp}), 16'({m.write, m.space}));
		if (fwd && wr)
			chk("mem wdata", 16'(d), 16'(m.wdata));
		chk("rsp valid", 16'h0001, 16'(r.valid));
		chk("refused", 16'(rf), 16'(r.refused));
		chk("rdata", 16'(e), 16'(r.rdata));
	endtask

	// settings are applied during reset and captured after release
	task automatic do_reset(input logic p, input logic e,
		input logic [1:0] s);
		@(posedge mclk);
		rst_n <= 1'h0;
		cfgP  <= p;
		cfgE  <= e;
		cfgS  <= s;
		repeat (2) @(posedge mclk);
		#1 chk("reset quiet", 16'h0000,
			16'(|{extMem, cpuMem, extRsp, cpuRsp}));
		@(posedge mclk);
		rst_n <= 1'h1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_capture;
		cwp_pkg::cwp_req_t m;
		cwp_pkg::cwp_rsp_t r;
		do_reset(1'h0, 1'h0, 2'h0);
		cpu_access(1'h0, 1'h1, 16'h0010, 14'h0000, m, r);
		chk("early mem", 16'h0000, 16'(m.valid));
		chk("early rsp", 16'h0000, 16'(r.valid));
		@(posedge mclk);
		cfgP <= 1'h1;
		cfgE <= 1'h1;
		cfgS <= 2'h3;
		xfer(0, 0, 0, 16'h0123, 14'h0000, 0, 1, 14'h0000);
		xfer(0, 1, 0, 16'h0124, 14'h1ABC, 0, 1, 14'h0000);
		xfer(0, 0, 1, 16'h0010, 14'h0000, 0, 1, 14'h0000);
		xfer(0, 1, 1, 16'h0011, 14'h00A5, 0, 1, 14'h0000);
		xfer(1, 0, 0, 16'h0123, 14'h0000, 1, 0, pat(16'h0123));
		xfer(1, 1, 1, 16'h0011, 14'h005A, 1, 0, 14'h0000);
		xfer(1, 0, 1, 16'h0012, 14'h0000, 1, 0, {6'h00, 8'h27});
		xfer(1, 1, 0, 16'h3FFF, 14'h0001, 0, 1, 14'h0000);
		$display("test capture done");
	endtask

	task automatic test_sizes;
		logic [1:0]  s;
		logic [15:0] l;
		for (int i = 0; i < 4; i++) begin
			s = 2'(i);
			l = lims[i];
			do_reset(s[0], s[1], s);
			if (l != 16'h0000)
				xfer(1, 1, 0, l - 16'h0001, 14'h0002, 0, 1, 14'h0000);
			xfer(1, 1, 0, l, 14'h0003, 1, 0, 14'h0000);
			xfer(0, 0, 1, 16'h0020, 14'h0000, s[1], !s[1],
				s[1] ? {6'h00, 8'h15} : 14'h0000);
			xfer(0, 0, 0, 16'h0100, 14'h0000, s[0], !s[0],
				s[0] ? pat(16'h0100) : 14'h0000);
			xfer(0, 1, 0, 16'h0101, 14'h0004, s[0], !s[0], 14'h0000);
		end
		$display("test sizes done");
	endtask

	task automatic test_ids;
		cwp_pkg::cwp_req_t m;
		cwp_pkg::cwp_req_t n;
		cwp_pkg::cwp_rsp_t r;
		cwp_pkg::cwp_rsp_t q;
		do_reset(1'h0, 1'h0, 2'h0);
		xfer(0, 0, 0, 16'h8003, 14'h0000, 0, 0, 14'h0000);
		for (int i = 0; i < 4; i++)
			xfer(1, 1, 0, 16'h8000 + 16'(i), 14'h1100 + 14'(i), 0, 0,
				14'h0000);
		for (int i = 0; i < 4; i++)
			xfer(0, 0, 0, 16'h8000 + 16'(i), 14'h0000, 0, 0,
				14'h1100 + 14'(i));
		xfer(0, 1, 0, 16'h8002, 14'h2A2A, 0, 0, 14'h0000);
		xfer(1, 0, 0, 16'h8002, 14'h0000, 0, 0, 14'h2A2A);
		xfer(1, 0, 0, 16'h8004, 14'h0000, 1, 0, pat(16'h8004));
		@(posedge mclk);
		fork
			cpu_access(1'h1, 1'h0, 16'h8001, 14'h0AAA, m, r);
			prog.access(1'h1, 1'h0, 16'h8001, 14'h1555, n, q);
		join
		chk("cpu id win", 16'h0000, 16'(r.refused));
		chk("ext id lose", 16'h0001, 16'(q.refused));
		xfer(0, 0, 0, 16'h8001, 14'h0000, 0, 0, 14'h0AAA);
		// cpu write then read of one id word on consecutive edges
		@(posedge mclk);
		cpuReq <= '{valid:1'h1, write:1'h1, space:1'h0, addr:16'h8003,
			wdata:14'h3C3C};
		@(posedge mclk);
		cpuReq <= '{valid:1'h1, write:1'h0, space:1'h0, addr:16'h8003,
			wdata:14'h0000};
		@(posedge mclk);
		cpuReq <= '0;
		@(posedge mclk);
		#1 chk("b2b rsp valid", 16'h0001, 16'(cpuRsp.valid));
		chk("b2b refused", 16'h0000, 16'(cpuRsp.refused));
		chk("b2b rdata", 16'h3C3C, 16'(cpuRsp.rdata));
		$display("test ids done");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n       = 1'h0;
		cfgP        = 1'h0;
		cfgE        = 1'h0;
		cfgS        = 2'h0;
		cpuReq      = '0;
		miscompares = 0;
		checked     = 0;
		lims = '{cwp_pkg::LIM_ALL, cwp_pkg::LIM_HALF, cwp_pkg::LIM_BOOT,
			cwp_pkg::LIM_OFF};
		test_capture();
		test_sizes();
		test_ids();
		final_report();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire
